// ===== gpm_port_b.v
// What this block does
// - Clamp each pin's digital input to ground during deep sleep modes.
// - No clamp where the pin's external interrupt request is enabled.
// - Disabled edge interrupt pin held high sets its flag on waking.
// - Inputs stay enabled in reset, active and idle; off in deep sleep.
// - Every pull-up is forced off while reset is asserted.
// - Pull-up follows override value, else on when dir/latch/disable = 010.
// - Output driver enable follows override value, else direction bit.
// - Driven value is override value when enabled, else the latch bit.
// - Toggle override enable inverts the pin's output latch bit.
// - Input enable follows its override value, else the sleep state.
// - Alternate input taken after clamp, before synchroniser.
// - Strobes shared per port; clock, sleep, pull-up disable shared.
// - Bits 7..4 carry timer compare outputs and pin-change 15..12.
// - Bits 3..0 carry SPI MISO, MOSI, SCK, SS and pin-change 11..8.
// - Writing one to a pin-input bit toggles the latch bit.
// - Pin input passes a two-stage synchroniser before reading.
// - All pins tri-stated as soon as reset becomes active.
// - Input with latch one enables pull-up; output drives latch level.
//
// Purpose: Port B pin control with alternate-function overrides, APB slave.
// Assumes: 125 MHz I_REF_CLK, synchronous active-low I_RST_N.
// Notes:   Registers answer with zero wait states; unmapped reads give 0 and pslverr.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ns
`include "gpm_map.vh"

module gpm_port_b
#(
  parameter WIDTH = 8
)
(
  // Clock and reset
  input  wire             I_REF_CLK,
  input  wire             I_RST_N,
  // APB slave
  input  wire             I_PSEL,
  input  wire             I_PENABLE,
  input  wire             I_PWRITE,
  input  wire [11:0]      I_PADDR,
  input  wire [31:0]      I_PWDATA,
  input  wire [3:0]       I_PSTRB,
  output reg  [31:0]      O_PRDATA,
  output wire             O_PREADY,
  output wire             O_PSLVERR,
  // Pads
  input  wire [WIDTH-1:0] I_PAD,
  output wire [WIDTH-1:0] O_PAD,
  output wire [WIDTH-1:0] O_PAD_OE_N,
  output wire [WIDTH-1:0] O_PULLUP,
  // Timer compare outputs, bits 7..4
  input  wire             I_TIMER2_COMPARE_A_OUT,
  input  wire             I_TIMER2_COMPARE_A_EN,
  input  wire             I_TIMER1_COMPARE_B_OUT,
  input  wire             I_TIMER1_COMPARE_B_EN,
  input  wire             I_TIMER1_COMPARE_A_OUT,
  input  wire             I_TIMER1_COMPARE_A_EN,
  input  wire             I_TIMER0_COMPARE_A_OUT,
  input  wire             I_TIMER0_COMPARE_A_EN,
  // SPI slave and master outputs
  input  wire             I_SPI_SLAVE_OUT,
  input  wire             I_SPI_MASTER_OUT,
  input  wire             I_SPI_SCK_OUT,
  // Pin-change mask 15..8 and toggle overrides
  input  wire [WIDTH-1:0] I_PIN_CHANGE_MASK,
  input  wire [WIDTH-1:0] I_TOGGLE_OVERRIDE_ENABLE,
  // Sleep controller
  input  wire             I_DEEP_SLEEP,
  // Alternate inputs
  output wire [WIDTH-1:0] O_PIN_CHANGE_SOURCE,
  output wire             O_SPI_MASTER_IN,
  output wire             O_SPI_SLAVE_IN,
  output wire             O_SPI_SCK_IN,
  output wire             O_SPI_SS_N,
  // Wake flag for disabled edge interrupt pin
  output wire             O_WAKE_EDGE_FLAG
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [WIDTH-1:0] dir_q;
  reg  [WIDTH-1:0] dir_d;
  reg  [WIDTH-1:0] latch_q;
  reg  [WIDTH-1:0] latch_d;
  reg  [3:0]       ctrl_q;
  reg  [3:0]       ctrl_d;
  reg              wake_q;
  reg              wake_d;
  reg              sleep_q;
  reg  [WIDTH-1:0] pad_held_q;
  wire [WIDTH-1:0] pin_sync;
  wire [WIDTH-1:0] alt_di;

  wire global_pullup_disable   = ctrl_q[`GPM_CTRL_PUD];
  wire spe   = ctrl_q[`GPM_CTRL_SPE];
  wire mstr  = ctrl_q[`GPM_CTRL_MSTR];
  wire pcie  = ctrl_q[`GPM_CTRL_PCIE];
  wire spi_m = spe & mstr;

  // Port-wide strobes, shared by all pins
  wire wr_acc    = I_PSEL & I_PENABLE & I_PWRITE & I_PSTRB[0];
  wire wr_latch  = wr_acc & (I_PADDR == `GPM_OFS_LATCH);
  wire wr_toggle = wr_acc & (I_PADDR == `GPM_OFS_PIN);
  wire wr_dir    = wr_acc & (I_PADDR == `GPM_OFS_DIR);
  wire wr_ctrl   = wr_acc & (I_PADDR == `GPM_OFS_CTRL);
  wire wr_sleep  = wr_acc & (I_PADDR == `GPM_OFS_SLEEP);

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin override signals
  reg [WIDTH-1:0] pullup_override_enable;
  reg [WIDTH-1:0] pullup_override_value;
  reg [WIDTH-1:0] direction_override_enable;
  reg [WIDTH-1:0] value_override_enable;
  reg [WIDTH-1:0] value_override_value;
  reg [WIDTH-1:0] input_enable_override_enable;

  // Alternate function table for port B
  always @*
  begin
    pullup_override_enable  = {4'h0, {4{spi_m}}};
    pullup_override_value  = {4'h0, latch_q[3:0] & {4{global_pullup_disable}}};
    direction_override_enable  = {4'h0, {4{spi_m}}};
    value_override_enable  = {I_TIMER2_COMPARE_A_EN, I_TIMER1_COMPARE_B_EN,
             I_TIMER1_COMPARE_A_EN, I_TIMER0_COMPARE_A_EN,
             1'b0, spi_m, spi_m, 1'b0};
    value_override_value  = {I_TIMER2_COMPARE_A_OUT, I_TIMER1_COMPARE_B_OUT,
             I_TIMER1_COMPARE_A_OUT, I_TIMER0_COMPARE_A_OUT,
             I_SPI_SLAVE_OUT, I_SPI_MASTER_OUT, I_SPI_SCK_OUT, 1'b0};
    input_enable_override_enable = I_PIN_CHANGE_MASK & {WIDTH{pcie}};
  end

  // Pin cells, one per bit; bit 7 drives only when its direction is set
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_pin
      gpm_pin_cell u_cell
      (
        .i_clk      (I_REF_CLK),
        .i_rst_n    (I_RST_N),
        .i_dir      (dir_q[g]),
        .i_latch    (latch_q[g]),
        .i_pud      (global_pullup_disable),
        .i_sleep    (I_DEEP_SLEEP),
        .i_pullup_override_enable     (pullup_override_enable[g]),
        .i_pullup_override_value     (pullup_override_value[g]),
        .i_direction_override_enable     (direction_override_enable[g]),
        .i_direction_override_value     (1'b0),
        .i_value_override_enable     (value_override_enable[g]),
        .i_value_override_value     (value_override_value[g]),
        .i_input_enable_override_enable    (input_enable_override_enable[g]),
        .i_input_enable_override_value    (1'b1),
        .i_pad      (I_PAD[g]),
        .o_pad      (O_PAD[g]),
        .o_pad_oe_n (O_PAD_OE_N[g]),
        .o_pullup   (O_PULLUP[g]),
        .o_alt_di   (alt_di[g]),
        .o_pin_q    (pin_sync[g])
      );
    end
  endgenerate

  // Alternate inputs, unsynchronised
  assign O_PIN_CHANGE_SOURCE = alt_di;
  assign O_SPI_MASTER_IN     = alt_di[3];
  assign O_SPI_SLAVE_IN      = alt_di[2];
  assign O_SPI_SCK_IN        = alt_di[1];
  assign O_SPI_SS_N          = alt_di[0];

  ////////////////////////////////////////////////////////////////////////////
  // Register next values
  always @*
  begin
    dir_d   = dir_q;
    latch_d = latch_q ^ I_TOGGLE_OVERRIDE_ENABLE;
    ctrl_d  = ctrl_q;
    wake_d  = wake_q;
    if (wr_latch)
      latch_d = I_PWDATA[WIDTH-1:0] ^ I_TOGGLE_OVERRIDE_ENABLE;
    if (wr_toggle)
      latch_d = latch_d ^ I_PWDATA[WIDTH-1:0];
    if (wr_dir)
      dir_d = I_PWDATA[WIDTH-1:0];
    if (wr_ctrl)
      ctrl_d = I_PWDATA[3:0];
    // Software clears the wake flag by writing one
    if (wr_sleep && I_PWDATA[`GPM_SLP_WAKEFLG])
      wake_d = 1'b0;
    // Clamp release on a pin held high but not enabled is a logic change
    if (sleep_q && !I_DEEP_SLEEP && |(pad_held_q & ~input_enable_override_enable))
      wake_d = 1'b1;
  end

  // Register update
  always @(posedge I_REF_CLK)
  begin
    if (!I_RST_N)
    begin
      dir_q      <= `GPM_RST_BYTE;
      latch_q    <= `GPM_RST_BYTE;
      ctrl_q     <= 4'h0;
      wake_q     <= 1'b0;
      sleep_q    <= 1'b0;
      pad_held_q <= `GPM_RST_BYTE;
    end
    else
    begin
      dir_q      <= dir_d;
      latch_q    <= latch_d;
      ctrl_q     <= ctrl_d;
      wake_q     <= wake_d;
      sleep_q    <= I_DEEP_SLEEP;
      // Freeze the last unclamped pin levels while asleep, so the exit check sees them
      if (!I_DEEP_SLEEP)
        pad_held_q <= pin_sync;
    end
  end

  assign O_WAKE_EDGE_FLAG = wake_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB read and answer
  reg        rd_hit;
  reg [31:0] rd_val;

  always @*
  begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    if (I_PADDR == `GPM_OFS_PIN)
      rd_val = {24'h00_0000, pin_sync};
    else if (I_PADDR == `GPM_OFS_DIR)
      rd_val = {24'h00_0000, dir_q};
    else if (I_PADDR == `GPM_OFS_LATCH)
      rd_val = {24'h00_0000, latch_q};
    else if (I_PADDR == `GPM_OFS_CTRL)
      rd_val = {28'h000_0000, ctrl_q};
    else if (I_PADDR == `GPM_OFS_SLEEP)
      rd_val = {30'h0000_0000, wake_q, I_DEEP_SLEEP};
    else
      rd_hit = 1'b0;
  end

  // Read data captured in the setup cycle
  always @(posedge I_REF_CLK)
  begin
    if (!I_RST_N)
      O_PRDATA <= 32'h0000_0000;
    else if (I_PSEL && !I_PENABLE && !I_PWRITE)
      O_PRDATA <= rd_val;
  end

  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~rd_hit;

endmodule // gpm_port_b

// ===== gpm_map.vh
// Purpose: Constants for the port B pin override mux.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes:   Offsets are byte addresses.
`ifndef GPM_MAP_VH
`define GPM_MAP_VH

// Register offsets
`define GPM_OFS_PIN      12'h000
`define GPM_OFS_DIR      12'h004
`define GPM_OFS_LATCH    12'h008
`define GPM_OFS_CTRL     12'h00c
`define GPM_OFS_SLEEP    12'h010

// Control register fields
`define GPM_CTRL_PUD     0
`define GPM_CTRL_SPE     1
`define GPM_CTRL_MSTR    2
`define GPM_CTRL_PCIE    3

// Sleep register fields
`define GPM_SLP_DEEP     0
`define GPM_SLP_WAKEFLG  1

// Reset values
`define GPM_RST_BYTE     8'h00

`endif

// ===== gpm_pin_cell.v
// Purpose: One port pin: override mux, input clamp, synchroniser.
// Assumes: Pad input is asynchronous to i_clk.
// Notes:   Pad controls are combinational from the override inputs.
`timescale 1ns/1ns

module gpm_pin_cell
(
  // Clock and reset
  input  wire i_clk,
  input  wire i_rst_n,
  // Register bits and shared controls
  input  wire i_dir,
  input  wire i_latch,
  input  wire i_pud,
  input  wire i_sleep,
  // Per-pin overrides
  input  wire i_pullup_override_enable,
  input  wire i_pullup_override_value,
  input  wire i_direction_override_enable,
  input  wire i_direction_override_value,
  input  wire i_value_override_enable,
  input  wire i_value_override_value,
  input  wire i_input_enable_override_enable,
  input  wire i_input_enable_override_value,
  // Pad
  input  wire i_pad,
  output wire o_pad,
  output wire o_pad_oe_n,
  output wire o_pullup,
  // Inputs to logic
  output wire o_alt_di,
  output reg  o_pin_q
);

  reg  sync_lat_q;
  wire drv_en;
  wire in_en;

  // Output driver enable and value
  assign drv_en     = i_direction_override_enable ? i_direction_override_value : i_dir;
  assign o_pad      = i_value_override_enable ? i_value_override_value : i_latch;
  // Tri-state as soon as reset is low, no clock needed
  assign o_pad_oe_n = ~(drv_en & i_rst_n);
  // Pull-up, forced off during reset
  assign o_pullup   = i_rst_n & (i_pullup_override_enable ? i_pullup_override_value : (~i_dir & i_latch & ~i_pud));
  // Input enable: clamp in deep sleep unless overridden
  assign in_en      = i_input_enable_override_enable ? i_input_enable_override_value : ~i_sleep;
  // Schmitt output clamped to ground, before the synchroniser
  assign o_alt_di   = i_pad & in_en;

  // Synchroniser: first stage feeds only the second
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      sync_lat_q <= 1'b0;
      o_pin_q    <= 1'b0;
    end
    else
    begin
      sync_lat_q <= o_alt_di;
      o_pin_q    <= sync_lat_q;
    end
  end

endmodule // gpm_pin_cell

// ===== gpm_port_b_asserts.sv
// Purpose: Port-level checks for the port B pin mux.
// Assumes: Pad level returns on I_PAD; SPI master off.
// Notes:   Reset checks run while reset is held.
`timescale 1ns/1ns
module gpm_port_b_asserts #(parameter WIDTH = 8)
(
  input wire I_REF_CLK, I_RST_N, I_PSEL, I_PENABLE, I_PWRITE, I_DEEP_SLEEP,
  input wire [11:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  input wire [3:0] I_PSTRB,
  input wire [WIDTH-1:0] I_PAD, O_PAD, O_PAD_OE_N, O_PULLUP, O_PIN_CHANGE_SOURCE,
  input wire [WIDTH-1:0] I_TOGGLE_OVERRIDE_ENABLE, I_PIN_CHANGE_MASK,
  input wire I_TIMER2_COMPARE_A_OUT, I_TIMER2_COMPARE_A_EN, I_TIMER0_COMPARE_A_EN,
  input wire O_SPI_MASTER_IN, O_SPI_SLAVE_IN, O_SPI_SCK_IN, O_SPI_SS_N
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  // Reset forces pads safe, whatever the registers hold
  property p_pu_rst; !I_RST_N |-> O_PULLUP == '0; endproperty
  a_pu_rst: assert property (p_pu_rst) else $error("pull-up on in reset");
  property p_oe_rst; !I_RST_N |-> &O_PAD_OE_N; endproperty
  a_oe_rst: assert property (p_oe_rst) else $error("pin driven in reset");
  // Pad controls in run
  property p_val7; disable iff (!I_RST_N)
    I_TIMER2_COMPARE_A_EN && !O_PAD_OE_N[7] |-> O_PAD[7] == I_TIMER2_COMPARE_A_OUT; endproperty
  a_val7: assert property (p_val7) else $error("bit 7 ignores timer value");
  property p_pu_drv; disable iff (!I_RST_N) |O_PULLUP[7:4] |-> ~|(O_PULLUP[7:4] & ~O_PAD_OE_N[7:4]); endproperty
  a_pu_drv: assert property (p_pu_drv) else $error("pull-up on a driven pin");
  property p_tog; disable iff (!I_RST_N)
    (I_TOGGLE_OVERRIDE_ENABLE[7] && !I_PSEL && !O_PAD_OE_N[7] && !I_TIMER2_COMPARE_A_EN)
    ##1 (!O_PAD_OE_N[7] && !I_TIMER2_COMPARE_A_EN) |-> O_PAD[7] != $past(O_PAD[7]); endproperty
  a_tog: assert property (p_tog) else $error("toggle override lost");
  property p_pinwr; disable iff (!I_RST_N)
    (I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == 12'h000 && I_PSTRB[0] && I_PWDATA[4]
    && !I_TOGGLE_OVERRIDE_ENABLE[4] && !O_PAD_OE_N[4] && !I_TIMER0_COMPARE_A_EN)
    ##1 (!O_PAD_OE_N[4] && !I_TIMER0_COMPARE_A_EN) |-> O_PAD[4] != $past(O_PAD[4]); endproperty
  a_pinwr: assert property (p_pinwr) else $error("pin write did not toggle");
  // Alternate inputs: unmasked pins clamp in deep sleep, raw pad otherwise
  property p_clamp; disable iff (!I_RST_N) I_DEEP_SLEEP |-> (O_PIN_CHANGE_SOURCE & ~I_PIN_CHANGE_MASK) == '0; endproperty
  a_clamp: assert property (p_clamp) else $error("input not clamped");
  property p_awake; disable iff (!I_RST_N) !I_DEEP_SLEEP |-> O_PIN_CHANGE_SOURCE == I_PAD; endproperty
  a_awake: assert property (p_awake) else $error("input not passed through");
  property p_spi; disable iff (!I_RST_N)
    I_RST_N |-> {O_SPI_MASTER_IN, O_SPI_SLAVE_IN, O_SPI_SCK_IN, O_SPI_SS_N} == O_PIN_CHANGE_SOURCE[3:0]; endproperty
  a_spi: assert property (p_spi) else $error("SPI input mapping wrong");
endmodule // gpm_port_b_asserts

bind gpm_port_b gpm_port_b_asserts #(.WIDTH(WIDTH)) chk_u (.I_REF_CLK, .I_RST_N, .I_PSEL, .I_PENABLE,
  .I_PWRITE, .I_DEEP_SLEEP, .I_PADDR, .I_PWDATA, .I_PSTRB, .I_PAD, .O_PAD, .O_PAD_OE_N, .O_PULLUP,
  .O_PIN_CHANGE_SOURCE, .I_TOGGLE_OVERRIDE_ENABLE, .I_PIN_CHANGE_MASK, .I_TIMER2_COMPARE_A_OUT,
  .I_TIMER2_COMPARE_A_EN, .I_TIMER0_COMPARE_A_EN, .O_SPI_MASTER_IN, .O_SPI_SLAVE_IN, .O_SPI_SCK_IN, .O_SPI_SS_N);

// ===== gpm_pad_model.sv
// Purpose: Pads and board around port B.
// Assumes: Bench decides where an external driver sits.
// Notes:   A floating line wanders so it never looks like a held value.
`timescale 1ns/1ns
module gpm_pad_model
(
  input  wire       i_clk,
  input  wire [7:0] i_oe_n, i_pad, i_pullup, i_ext_en, i_ext_val,
  output wire [7:0] o_lvl
);
  reg [7:0] float_q = 8'h00;
  // Undriven, unpulled lines change every cycle
  always @(posedge i_clk)
    float_q <= ~float_q;
  // Device driver, then external driver, then pull-up
  assign o_lvl = (~i_oe_n & i_pad) | (i_oe_n & i_ext_en & i_ext_val)
               | (i_oe_n & ~i_ext_en & (i_pullup | float_q));
endmodule // gpm_pad_model

// ===== tb_top.sv
// Purpose: Self-checking bench for the port B pin mux.
// Assumes: Zero-wait APB slave; SPI master outputs held low.
// Notes:   Reads are noted in a queue and judged by a monitor.
`timescale 1ns/1ns
`include "gpm_map.vh"
module tb_top;
  reg clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, deep = 1'b0, global_pullup_disable;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [3:0] pstrb = 4'hf, t_out = 4'h0, t_en = 4'h0;
  reg [7:0] mask = 8'h00, tog = 8'h00, ext_en = 8'h00, ext_val = 8'h00, dv, lv;
  reg [15:0] r = 16'd16714;
  reg [32:0] exp_q[$];
  integer num_errors = 0, n_compared = 0, i, k;
  wire [31:0] prdata;
  wire pready, pslverr, miso, mosi, sck, ss_n, wake;
  wire [7:0] pad_i, pad_o, oe_n, pu, pcs;
  always #4 clk = ~clk;
  gpm_port_b #(.WIDTH(8)) dut_u (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_PAD(pad_i), .O_PAD(pad_o), .O_PAD_OE_N(oe_n), .O_PULLUP(pu),
    .I_TIMER2_COMPARE_A_OUT(t_out[3]), .I_TIMER2_COMPARE_A_EN(t_en[3]), .I_TIMER1_COMPARE_B_OUT(t_out[2]),
    .I_TIMER1_COMPARE_B_EN(t_en[2]), .I_TIMER1_COMPARE_A_OUT(t_out[1]), .I_TIMER1_COMPARE_A_EN(t_en[1]),
    .I_TIMER0_COMPARE_A_OUT(t_out[0]), .I_TIMER0_COMPARE_A_EN(t_en[0]), .I_SPI_SLAVE_OUT(1'b0),
    .I_SPI_MASTER_OUT(1'b0), .I_SPI_SCK_OUT(1'b0), .I_PIN_CHANGE_MASK(mask), .I_TOGGLE_OVERRIDE_ENABLE(tog),
    .I_DEEP_SLEEP(deep), .O_PIN_CHANGE_SOURCE(pcs), .O_SPI_MASTER_IN(miso), .O_SPI_SLAVE_IN(mosi),
    .O_SPI_SCK_IN(sck), .O_SPI_SS_N(ss_n), .O_WAKE_EDGE_FLAG(wake));
  gpm_pad_model pads_u (.i_clk(clk), .i_oe_n(oe_n), .i_pad(pad_o), .i_pullup(pu), .i_ext_en(ext_en),
    .i_ext_val(ext_val), .o_lvl(pad_i));
  // Pseudo-random source for register values
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task cmp(input [32:0] got, input [32:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // One APB transfer, held until pready is seen at an edge
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      k = 0;
      @(posedge clk);
      while (pready !== 1'b1 && k < 16)
      begin
        @(posedge clk);
        k = k + 1;
      end
      if (k == 16)
      begin
        num_errors = num_errors + 1;
        final_report;
      end
      else
      begin
        psel <= 1'b0;
        pen <= 1'b0;
      end
    end
  endtask
  task rd(input [11:0] a, input [32:0] e);
    begin
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
    end
  endtask
  task pads(input [7:0] d, input [7:0] l, input p);
    begin
      cmp({25'h0, oe_n}, {25'h0, ~d});
      cmp({25'h0, pad_o & d}, {25'h0, l & d});
      cmp({25'h0, pu}, {25'h0, ~d & l & {8{~p}}});
    end
  endtask
  // Read monitor: pairs each completed read with the oldest note
  always @(posedge clk)
    if (psel && pen && pready && !pwr)
      cmp({pslverr, prdata}, exp_q.size() ? exp_q.pop_front() : 33'h1ffffffff);
  initial
  begin
    repeat (20) @(posedge clk);
    cmp({25'h0, oe_n}, 33'hff);
    cmp({25'h0, pu}, 33'h0);
    rst_n <= 1'b1;
    rd(`GPM_OFS_DIR, 33'h0);
    rd(`GPM_OFS_LATCH, 33'h0);
    $display("reset test done");
    for (i = 0; i < 6; i = i + 1)
    begin
      r = lfsr(r);
      dv = r[7:0];
      lv = r[15:8];
      global_pullup_disable = r[3];
      apb(1'b1, `GPM_OFS_DIR, {24'h0, dv});
      apb(1'b1, `GPM_OFS_LATCH, {24'h0, lv});
      apb(1'b1, `GPM_OFS_CTRL, {31'h0, global_pullup_disable});
      rd(`GPM_OFS_LATCH, {25'h0, lv});
      @(negedge clk);
      pads(dv, lv, global_pullup_disable);
    end
    $display("pad control test done");
    apb(1'b1, `GPM_OFS_DIR, 32'hff);
    apb(1'b1, `GPM_OFS_LATCH, 32'h0);
    @(posedge clk);
    tog <= 8'h90;
    @(posedge clk);
    tog <= 8'h00;
    apb(1'b1, `GPM_OFS_PIN, 32'h1f);
    rd(`GPM_OFS_LATCH, 33'h8f);
    @(posedge clk);
    t_en <= 4'hf;
    t_out <= 4'ha;
    @(negedge clk);
    cmp({29'h0, pad_o[7:4]}, 33'ha);
    @(posedge clk);
    t_en <= 4'h0;
    $display("toggle and override test done");
    apb(1'b1, `GPM_OFS_DIR, 32'h0);
    apb(1'b1, `GPM_OFS_LATCH, 32'h0);
    apb(1'b1, `GPM_OFS_CTRL, 32'h8);
    ext_en <= 8'hff;
    ext_val <= 8'hff;
    mask <= 8'h01;
    repeat (3) @(posedge clk);
    rd(`GPM_OFS_PIN, 33'hff);
    deep <= 1'b1;
    repeat (3) @(posedge clk);
    cmp({25'h0, pcs}, 33'h01);
    rd(`GPM_OFS_PIN, 33'h01);
    deep <= 1'b0;
    repeat (3) @(posedge clk);
    cmp({25'h0, pcs}, 33'hff);
    cmp({32'h0, wake}, 33'h1);
    rd(`GPM_OFS_SLEEP, 33'h2);
    apb(1'b1, `GPM_OFS_SLEEP, 32'h2);
    rd(`GPM_OFS_SLEEP, 33'h0);
    rd(12'h020, 33'h100000000);
    repeat (4) @(posedge clk);
    cmp(exp_q.size(), 33'h0);
    $display("sleep test done");
    final_report;
  end
endmodule // tb_top
